// ---- logic/pwmcs_pkg.sv ----
// pwmcs_pkg: constants of the pwm clock scale, counter and period block.
// assumes one bus clock domain; offsets are byte addresses on ahb-lite.
package pwmcs_pkg;
  localparam int NCH_MAX = 8;
  localparam int NPAIR_MAX = 4;
  localparam logic [7:0] OFS_FAMILY = 8'h00;
  localparam logic [7:0] OFS_SCALED = 8'h04;
  localparam logic [7:0] OFS_SCALE_A = 8'h08;
  localparam logic [7:0] OFS_SCALE_B = 8'h0C;
  localparam logic [2:0] REGION_MISC = 3'h0;
  localparam logic [2:0] REGION_COUNTER = 3'h1;
  localparam logic [2:0] REGION_PERIOD = 3'h2;
  localparam int REGION_LSB = 5;
  localparam int INDEX_LSB = 2;
  localparam logic [7:0] FAMILY_RESET = 8'h00;
  localparam logic [7:0] SCALED_RESET = 8'h00;
  localparam logic [7:0] SCALE_A_RESET = 8'h00;
  localparam logic [7:0] SCALE_B_RESET = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  // channels 2,3,6,7 have the families swapped; index bit 1 marks them
  localparam int FAMILY_SWAP_BIT = 1;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;
endpackage : pwmcs_pkg

// ---- logic/pwmcs_top.sv ----
// pwmcs_top: clock family select, scaled clocks, channel counters, double-buffered periods.
// assumes clk_a_tick/clk_b_tick are one-cycle enables from the prescaler on clk, and
// that enable, center-align and concatenate controls come from logic on clk.
// Operation
// - ch 0,1,4,5: select 0 is A family
// - ch 2,3,6,7: select 0 is B family
// - scaled and family bits pick A/B/SA/SB
// - absent channels' select bits read zero
// - SA is A divided by scale, halved
// - scale A zero counts as 256
// - scale A write reloads its down counter
// - SB likewise from B, zero is 256
// - scale B write reloads; resets to zero
// - 8-bit counter per channel, read harmless
// - left aligned counts 0 to period-1
// - center aligned counts up then down
// - counter write clears, up, loads period
// - counter cleared at each period end
// - disabled counter holds, resumes when enabled
// - concatenated pair: any byte write clears both
// - enabled period change waits for period end
// - disabled: period write reaches active at once
// - period read returns last written value
// - period is clock times period, center twice
// - absent channel registers read zero, ignore writes
// - even byte high, odd channel governs pair
//
// Register access over AHB-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pwmcs_top #(
  parameter int NUM_CH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [pwmcs_pkg::NCH_MAX-1:0] chan_enable,
  input wire logic [pwmcs_pkg::NCH_MAX-1:0] center_align,
  input wire logic [pwmcs_pkg::NPAIR_MAX-1:0] concat_pair,
  input wire logic clk_a_tick,
  input wire logic clk_b_tick,
  output logic [pwmcs_pkg::NCH_MAX-1:0] chan_tick,
  output logic [pwmcs_pkg::NCH_MAX-1:0] period_end,
  output logic [pwmcs_pkg::NCH_MAX-1:0] cnt_cleared,
  output logic [pwmcs_pkg::NCH_MAX-1:0] count_down,
  output logic [8*pwmcs_pkg::NCH_MAX-1:0] chan_count
);
  import pwmcs_pkg::*;

  localparam logic [NCH_MAX-1:0] CH_MASK = NCH_MAX'((1 << NUM_CH) - 1);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // ---------------- ahb-lite slave, zero wait states
  logic ap_wr_q;
  logic [7:0] ap_addr_q;
  logic [31:0] hrdata_q;
  logic hready_q;
  logic ap_take;
  logic [7:0] rd_byte;

  logic [7:0] family_q;
  logic [7:0] scaled_q;
  logic [7:0] scale_q [2];
  logic [7:0] cnt_q [NCH_MAX];
  logic up_q [NCH_MAX];
  logic [7:0] per_buf_q [NCH_MAX];
  logic [7:0] per_act_q [NCH_MAX];

  assign ap_take = hsel && (htrans & HTRANS_NONSEQ_BIT) != 2'h0 && hready;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end else begin
      ap_wr_q <= ap_take && hwrite;
      ap_addr_q <= haddr[7:0];
    end
  end

  // read data is fetched in the address phase so it stands for the whole data phase
  always_comb begin
    rd_byte = 8'h00;
    case (haddr[7:REGION_LSB])
      REGION_MISC: begin
        case (haddr[7:0])
          OFS_FAMILY: rd_byte = family_q & CH_MASK;
          OFS_SCALED: rd_byte = scaled_q & CH_MASK;
          OFS_SCALE_A: rd_byte = scale_q[0];
          OFS_SCALE_B: rd_byte = scale_q[1];
          default: rd_byte = 8'h00;
        endcase
      end
      REGION_COUNTER: rd_byte = cnt_q[haddr[4:INDEX_LSB]];
      REGION_PERIOD: rd_byte = per_buf_q[haddr[4:INDEX_LSB]];
      default: rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hrdata_q <= 32'h0000_0000;
      hready_q <= 1'b1;
    end else begin
      hready_q <= 1'b1;
      if (ap_take && !hwrite) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hready_q;
  assign hresp = 1'b0;

  // ---------------- write strobes of the data phase
  logic wr_family;
  logic wr_scaled;
  logic wr_scale [2];
  logic [NCH_MAX-1:0] wr_cnt;
  logic [NCH_MAX-1:0] wr_per;

  always_comb begin
    wr_family = ap_wr_q && ap_addr_q == OFS_FAMILY;
    wr_scaled = ap_wr_q && ap_addr_q == OFS_SCALED;
    wr_scale[0] = ap_wr_q && ap_addr_q == OFS_SCALE_A;
    wr_scale[1] = ap_wr_q && ap_addr_q == OFS_SCALE_B;
    for (int c = 0; c < NCH_MAX; c++) begin
      wr_cnt[c] = ap_wr_q && ap_addr_q[7:REGION_LSB] == REGION_COUNTER &&
                  ap_addr_q[4:INDEX_LSB] == 3'(c) && CH_MASK[c];
      wr_per[c] = ap_wr_q && ap_addr_q[7:REGION_LSB] == REGION_PERIOD &&
                  ap_addr_q[4:INDEX_LSB] == 3'(c) && CH_MASK[c];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      family_q <= FAMILY_RESET;
      scaled_q <= SCALED_RESET;
    end else begin
      if (wr_family) begin
        family_q <= hwdata[7:0] & CH_MASK;
      end
      if (wr_scaled) begin
        scaled_q <= hwdata[7:0] & CH_MASK;
      end
    end
  end

  // ---------------- scaled clocks SA (0) and SB (1), as enables not clocks
  logic base_tick [2];
  logic scaled_tick [2];
  assign base_tick[0] = clk_a_tick;
  assign base_tick[1] = clk_b_tick;

  for (genvar s = 0; s < 2; s++) begin : g_scale
    logic [7:0] down_q;
    logic half_q;
    logic hit;
    assign hit = base_tick[s] && down_q == 8'h01;
    // a loaded zero walks 255..1, so it takes 256 ticks to hit
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        scale_q[s] <= (s == 0) ? SCALE_A_RESET : SCALE_B_RESET;
        down_q <= (s == 0) ? SCALE_A_RESET : SCALE_B_RESET;
        half_q <= 1'b0;
      end else if (wr_scale[s]) begin
        scale_q[s] <= hwdata[7:0];
        down_q <= hwdata[7:0];
      end else if (hit) begin
        down_q <= scale_q[s];
        half_q <= !half_q;
      end else if (base_tick[s]) begin
        down_q <= down_q - 8'h01;
      end
    end
    assign scaled_tick[s] = hit && half_q;
  end

  // ---------------- per-channel clock pick
  logic tick_v [NCH_MAX];
  logic sel_b [NCH_MAX];
  always_comb begin
    for (int c = 0; c < NCH_MAX; c++) begin
      sel_b[c] = family_q[c] ^ (((3'(c) >> FAMILY_SWAP_BIT) & 3'h1) != 3'h0);
      if (scaled_q[c]) begin
        tick_v[c] = sel_b[c] ? scaled_tick[1] : scaled_tick[0];
      end else begin
        tick_v[c] = sel_b[c] ? clk_b_tick : clk_a_tick;
      end
    end
  end

  // one count step: returns {end, up, count}
  function automatic logic [17:0] step(input logic [15:0] c, input logic [15:0] per,
                                       input logic up, input logic ca);
    logic wrap;
    wrap = ({1'b0, c} + 17'h0_0001) >= {1'b0, per};
    if (!ca) begin
      return wrap ? {2'b11, 16'h0000} : {2'b01, c + 16'h0001};
    end
    if (up) begin
      return wrap ? {2'b00, per} : {2'b01, c + 16'h0001};
    end
    return (c <= 16'h0001) ? {2'b11, 16'h0000} : {2'b00, c - 16'h0001};
  endfunction : step

  // ---------------- channel pairs
  logic go_v [NCH_MAX];
  logic clr_v [NCH_MAX];
  logic end_v [NCH_MAX];
  logic en_v [NCH_MAX];

  for (genvar p = 0; p < NPAIR_MAX; p++) begin : g_pair
    localparam int E = 2 * p;
    localparam int O = 2 * p + 1;
    if (p < NUM_CH / 2) begin : g_on
      logic cat;
      logic [17:0] res [2];
      logic [7:0] nxt [2];
      logic [17:0] r_cat;
      assign cat = concat_pair[p];
      // the odd channel's clock, enable and mode govern a concatenated pair
      assign r_cat = step({cnt_q[E], cnt_q[O]}, {per_act_q[E], per_act_q[O]},
                          up_q[O], center_align[O]);
      always_comb begin
        for (int k = 0; k < 2; k++) begin
          res[k] = step({8'h00, cnt_q[E + k]}, {8'h00, per_act_q[E + k]},
                        up_q[E + k], center_align[E + k]);
          if (cat) begin
            res[k] = r_cat;
            nxt[k] = (k == 0) ? r_cat[15:8] : r_cat[7:0];
            en_v[E + k] = chan_enable[O];
            go_v[E + k] = chan_enable[O] && tick_v[O];
            clr_v[E + k] = wr_cnt[E] || wr_cnt[O];
          end else begin
            nxt[k] = res[k][7:0];
            en_v[E + k] = chan_enable[E + k];
            go_v[E + k] = chan_enable[E + k] && tick_v[E + k];
            clr_v[E + k] = wr_cnt[E + k];
          end
          end_v[E + k] = go_v[E + k] && res[k][17] && !clr_v[E + k];
        end
      end
      for (genvar k = 0; k < 2; k++) begin : g_ch
        always_ff @(posedge clk) begin
          if (!reset_n) begin
            cnt_q[E + k] <= COUNTER_RESET;
            up_q[E + k] <= 1'b1;
            per_buf_q[E + k] <= PERIOD_RESET;
            per_act_q[E + k] <= PERIOD_RESET;
          end else begin
            if (clr_v[E + k]) begin
              cnt_q[E + k] <= COUNTER_RESET;
              up_q[E + k] <= 1'b1;
            end else if (go_v[E + k]) begin
              cnt_q[E + k] <= nxt[k];
              up_q[E + k] <= res[k][16];
            end
            if (wr_per[E + k]) begin
              per_buf_q[E + k] <= hwdata[7:0];
            end
            if (wr_per[E + k] && !en_v[E + k]) begin
              per_act_q[E + k] <= hwdata[7:0];
            end else if (!en_v[E + k] || end_v[E + k] || clr_v[E + k]) begin
              per_act_q[E + k] <= per_buf_q[E + k];
            end
          end
        end
      end
    end else begin : g_off
      for (genvar k = 0; k < 2; k++) begin : g_ch
        assign cnt_q[E + k] = 8'h00;
        assign up_q[E + k] = 1'b1;
        assign per_buf_q[E + k] = 8'h00;
        assign per_act_q[E + k] = 8'h00;
        assign go_v[E + k] = 1'b0;
        assign clr_v[E + k] = 1'b0;
        assign end_v[E + k] = 1'b0;
        assign en_v[E + k] = 1'b0;
      end
    end
  end

  // ---------------- registered strobes for the duty and output neighbours
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chan_tick <= '0;
      period_end <= '0;
      cnt_cleared <= '0;
      count_down <= '0;
    end else begin
      for (int c = 0; c < NCH_MAX; c++) begin
        chan_tick[c] <= tick_v[c] && CH_MASK[c];
        period_end[c] <= end_v[c];
        cnt_cleared[c] <= clr_v[c];
        count_down[c] <= !up_q[c];
      end
    end
  end

  for (genvar c = 0; c < NCH_MAX; c++) begin : g_cnt_out
    assign chan_count[8 * c +: 8] = cnt_q[c];
  end

  // ---------------- checks
  sequence s_scale_a_write;
    ap_wr_q && ap_addr_q == OFS_SCALE_A;
  endsequence

  a_family_swap: assert property (sel_b[2] == !family_q[2] && sel_b[0] == family_q[0])
    else $error("family pick wrong for channel 0 or 2");
  a_family_other: assert property (sel_b[6] == !family_q[6] && sel_b[5] == family_q[5])
    else $error("family pick wrong for channel 5 or 6");
  a_scaled_pick: assert property (scaled_q[0] && !family_q[0] |-> tick_v[0] == scaled_tick[0])
    else $error("channel 0 not on scaled clock a");
  a_absent_bits: assert property ((family_q & ~CH_MASK) == 8'h00)
    else $error("absent channel select bit set");
  a_scale_a_reload: assert property (s_scale_a_write |=> g_scale[0].down_q == $past(hwdata[7:0]))
    else $error("scale a counter not reloaded on write");
  a_scale_b_reload: assert property (wr_scale[1] |=> g_scale[1].down_q == scale_q[1])
    else $error("scale b counter not reloaded on write");
  a_scaled_half: assert property (scaled_tick[0] && !wr_scale[0] |=> !g_scale[0].half_q)
    else $error("scaled a pulse without halving");
  a_count_clear: assert property (wr_cnt[0] |=> cnt_q[0] == 8'h00 && up_q[0])
    else $error("counter write did not clear channel 0");
  a_hold_off: assert property (!en_v[0] && !clr_v[0] |=> $stable(cnt_q[0]))
    else $error("disabled channel 0 counter moved");
  a_left_wrap: assert property (go_v[0] && !concat_pair[0] && !center_align[0] && !clr_v[0]
                                && cnt_q[0] + 8'h01 == per_act_q[0] |=> cnt_q[0] == 8'h00)
    else $error("left aligned channel 0 did not wrap");
  a_period_direct: assert property (wr_per[1] && !en_v[1] |=> per_act_q[1] == per_buf_q[1])
    else $error("disabled period write not applied at once");
  a_period_held: assert property (en_v[1] && !end_v[1] && !clr_v[1] && !wr_per[1]
                                  |=> $stable(per_act_q[1]))
    else $error("active period changed mid period");

  sequence s_ch0_left_step;
    go_v[0] && !concat_pair[0] && !center_align[0] && !clr_v[0];
  endsequence
  sequence s_ch0_center_top;
    go_v[0] && !concat_pair[0] && center_align[0] && !clr_v[0] && up_q[0];
  endsequence

  // nine-bit compares so a count of ff cannot wrap into a false match
  a_left_count: assert property (s_ch0_left_step ##0 9'(cnt_q[0]) + 9'h001 < 9'(per_act_q[0])
                                 |=> cnt_q[0] == $past(cnt_q[0]) + 8'h01)
    else $error("left aligned channel 0 skipped a count");
  a_center_turn: assert property (s_ch0_center_top ##0 9'(cnt_q[0]) + 9'h001 >= 9'(per_act_q[0])
                                  |=> !up_q[0] && cnt_q[0] == per_act_q[0])
    else $error("center aligned channel 0 did not turn at the top");
  a_end_clear: assert property (end_v[0] |=> cnt_q[0] == 8'h00)
    else $error("channel 0 counter not cleared at period end");
  a_disabled_follow: assert property (!en_v[1] && !wr_per[1]
                                      |=> per_act_q[1] == $past(per_buf_q[1]))
    else $error("disabled channel 1 active period not following buffer");
  a_absent_scaled: assert property ((scaled_q & ~CH_MASK) == 8'h00)
    else $error("absent channel scaled bit set");
  a_concat_clear: assert property (wr_cnt[1] && concat_pair[0]
                                   |=> cnt_q[0] == 8'h00 && cnt_q[1] == 8'h00)
    else $error("concatenated pair not cleared by low byte write");
  a_scale_b_wrap: assert property (g_scale[1].hit && !wr_scale[1]
                                   |=> g_scale[1].down_q == scale_q[1])
    else $error("scale b counter not reloaded at one");
endmodule : pwmcs_top

// ---- verification/pwmcs_prescale_model.sv ----
// pwmcs_prescale_model: stand-in for the prescaler that makes clock a and b ticks.
// assumes the bench sets the ratios; ticks are one-cycle pulses on clk.
`timescale 1ns/1ps
module pwmcs_prescale_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] div_a,
  input wire logic [7:0] div_b,
  output logic clk_a_tick,
  output logic clk_b_tick
);
  logic [7:0] cnt_a_q;
  logic [7:0] cnt_b_q;
  // a ratio change is not synchronised, so the bench skips the first gap
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_a_q <= 8'h00;
      cnt_b_q <= 8'h00;
      clk_a_tick <= 1'b0;
      clk_b_tick <= 1'b0;
    end else begin
      clk_a_tick <= (cnt_a_q >= div_a - 8'h01);
      clk_b_tick <= (cnt_b_q >= div_b - 8'h01);
      cnt_a_q <= (cnt_a_q >= div_a - 8'h01) ? 8'h00 : cnt_a_q + 8'h01;
      cnt_b_q <= (cnt_b_q >= div_b - 8'h01) ? 8'h00 : cnt_b_q + 8'h01;
    end
  end
endmodule : pwmcs_prescale_model

// ---- verification/pwm_clock_scale_counter_period_test.sv ----
// pwm_clock_scale_counter_period_test: self-checking bench of pwmcs_top.
// assumes one ahb-lite master here and the prescaler model for the ticks.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("mismatch at %0t: got %0h want %0h", $time, a, e); end end
module pwm_clock_scale_counter_period_test;
  import pwmcs_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} pwmcs_row_t;
  // six channels so that channels 6 and 7 are absent
  localparam int NCH = 6;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0] chan_enable = 8'h00;
  logic [7:0] center_align = 8'h00;
  logic [3:0] concat_pair = 4'h0;
  logic [7:0] div_a = 8'h01;
  logic [7:0] div_b = 8'h01;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic clk_a_tick;
  logic clk_b_tick;
  logic [7:0] chan_tick;
  logic [7:0] period_end;
  logic [7:0] cnt_cleared;
  logic [7:0] count_down;
  logic [63:0] chan_count;
  logic [7:0] rd;
  logic ok;
  int failures = 0;
  int tests_run = 0;
  int n;
  int mx;
  pwmcs_row_t rows [16] = '{
    '{1'b0, 8'h00, 8'h00, 8'h00}, '{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h08, 8'h00, 8'h00},
    '{1'b0, 8'h0C, 8'h00, 8'h00}, '{1'b0, 8'h20, 8'h00, 8'h00}, '{1'b0, 8'h40, 8'h00, 8'hFF},
    '{1'b0, 8'h54, 8'h00, 8'hFF}, '{1'b0, 8'h58, 8'h00, 8'h00}, '{1'b1, 8'h00, 8'hFF, 8'h3F},
    '{1'b1, 8'h04, 8'hFF, 8'h3F}, '{1'b1, 8'h08, 8'hA5, 8'hA5}, '{1'b1, 8'h0C, 8'h5A, 8'h5A},
    '{1'b1, 8'h58, 8'h77, 8'h00}, '{1'b1, 8'h38, 8'h12, 8'h00}, '{1'b1, 8'h80, 8'h33, 8'h00},
    '{1'b1, 8'h44, 8'h09, 8'h09}};

  always #2.5 clk = ~clk;

  pwmcs_top #(.NUM_CH(NCH)) u_dut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan_enable(chan_enable),
    .center_align(center_align), .concat_pair(concat_pair), .clk_a_tick(clk_a_tick),
    .clk_b_tick(clk_b_tick), .chan_tick(chan_tick), .period_end(period_end),
    .cnt_cleared(cnt_cleared), .count_down(count_down), .chan_count(chan_count));

  pwmcs_prescale_model u_pre (.clk(clk), .reset_n(reset_n), .div_a(div_a), .div_b(div_b),
    .clk_a_tick(clk_a_tick), .clk_b_tick(clk_b_tick));

  task automatic stop_test();
    $display("compares %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // entered right after a rising edge; returns at the edge that ends the data phase
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= HTRANS_NONSEQ_BIT;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h00_0000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata[7:0];
  endtask : bus

  // cycles between two pulses of chan_tick (pe=0) or period_end (pe=1)
  task automatic gap(input bit pe, input int ch, output int g);
    logic [7:0] v;
    g = 0;
    mx = 0;
    do begin @(negedge clk); v = pe ? period_end : chan_tick; end while (!v[ch]);
    do begin
      @(negedge clk);
      v = pe ? period_end : chan_tick;
      g++;
      if (chan_count[8*ch +: 8] > mx) mx = chan_count[8*ch +: 8];
    end while (!v[ch] && g < 2000);
    @(posedge clk);
  endtask : gap

  task automatic sel_case(input logic [7:0] fam, input logic [7:0] scl, input logic [7:0] sa,
                          input logic [7:0] sb, input int ch, input int exp);
    bus(1'b1, OFS_FAMILY, fam);
    bus(1'b1, OFS_SCALED, scl);
    bus(1'b1, OFS_SCALE_A, sa);
    bus(1'b1, OFS_SCALE_B, sb);
    gap(1'b0, ch, n);
    gap(1'b0, ch, n);
    `CHK(n, exp)
  endtask : sel_case

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    stop_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    #1;
    `CHK({hreadyout, hresp}, 2'b10)
    `CHK(chan_count, 64'h0000_0000_0000_0000)
    @(posedge clk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      `CHK(rd, rows[i].e)
    end
    $display("test registers done");
    div_b <= 8'h03;
    chan_enable <= 8'h3F;
    sel_case(8'h00, 8'h00, 8'h01, 8'h01, 0, 1);
    sel_case(8'h00, 8'h00, 8'h01, 8'h01, 2, 3);
    sel_case(8'h05, 8'h00, 8'h01, 8'h01, 0, 3);
    sel_case(8'h05, 8'h00, 8'h01, 8'h01, 2, 1);
    sel_case(8'h00, 8'h01, 8'h02, 8'h01, 0, 4);
    sel_case(8'h00, 8'h01, 8'h00, 8'h01, 0, 512);
    sel_case(8'h00, 8'h04, 8'h01, 8'h03, 2, 18);
    sel_case(8'h04, 8'h04, 8'h01, 8'h03, 2, 2);
    $display("test clock select done");
    chan_enable <= 8'h3E;
    bus(1'b1, 8'h40, 8'h03);
    chan_enable <= 8'h3F;
    gap(1'b1, 0, n);
    gap(1'b1, 0, n);
    `CHK({n, mx}, {32'd3, 32'd2})
    center_align <= 8'h01;
    gap(1'b1, 0, n);
    gap(1'b1, 0, n);
    `CHK({n, mx}, {32'd6, 32'd3})
    $display("test counting done");
    center_align <= 8'h00;
    bus(1'b1, 8'h40, 8'hC8);
    bus(1'b1, 8'h20, 8'h00);
    bus(1'b1, 8'h40, 8'h32);
    bus(1'b0, 8'h40, 8'h00);
    `CHK(rd, 8'h32)
    n = 0;
    do begin @(negedge clk); n++; end while (!period_end[0] && n < 1000);
    `CHK(n > 150, 1'b1)
    gap(1'b1, 0, n);
    `CHK(n, 50)
    $display("test buffered period done");
    center_align <= 8'h01;
    n = 0;
    do begin @(negedge clk); n++; end while (count_down[0] !== 1'b1 && n < 1000);
    @(posedge clk);
    bus(1'b1, 8'h20, 8'h99);
    #1;
    `CHK(chan_count[7:0], 8'h00)
    repeat (2) @(negedge clk);
    `CHK(count_down[0], 1'b0)
    @(posedge clk);
    chan_enable <= 8'h3E;
    repeat (3) @(posedge clk);
    rd = chan_count[7:0];
    repeat (20) @(posedge clk);
    `CHK(chan_count[7:0], rd)
    chan_enable <= 8'h3F;
    repeat (4) @(posedge clk);
    `CHK(chan_count[7:0] !== rd, 1'b1)
    $display("test clear and hold done");
    concat_pair <= 4'h1;
    repeat (10) @(posedge clk);
    bus(1'b1, 8'h20, 8'h01);
    #1;
    `CHK(chan_count[15:0], 16'h0000)
    ok = 1'b0;
    repeat (3) begin
      @(negedge clk);
      if (cnt_cleared[1:0] === 2'b11) ok = 1'b1;
    end
    `CHK(ok, 1'b1)
    $display("test concatenated pair done");
    stop_test();
  end
endmodule : pwm_clock_scale_counter_period_test
